// ==== logic/ium_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - six configurable inputs beside fixed ones
// - two fixed inputs: emergency stop, remote start
// - usage type selects which fields apply
// - off usage: no status, no action
// - command usage forwards logical state as quantity
// - event usage raises configured event when active
// - link usage: link readback only, no action
// - unconnected inputs read physical high
// - polarity maps physical level to logical
// - highest numbered channel wins shared quantity
// - local config writes need access level two
// - delay qualifies event usage only
// - readback of id, usage, levels, polarity
// - unmapped command quantities read zero
module ium_top
  import ium_pkg::*;
#(
  parameter int N_CH = NUM_CH
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic [N_CH-1:0]     din_pin,
  input  wire logic                estop_pin,
  input  wire logic                rstart_pin,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [NUM_QTY-1:0]       cmd_qty,
  output logic [NUM_QTY-1:0]       event_raise,
  output logic [N_CH-1:0]          link_state,
  output logic                     estop,
  output logic                     remote_start,
  output logic                     irq
);

  if (N_CH != NUM_CH)
    $error("ium_top serves exactly six channels");

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0]     cfg [N_CH];
  logic [31:0]     next_cfg [N_CH];
  logic [N_CH-1:0] stat_irq;
  logic [N_CH-1:0] next_stat_irq;
  logic [N_CH-1:0] mask;
  logic [N_CH-1:0] next_mask;
  logic [1:0]      access;
  logic [1:0]      next_access;

  // ************************************************************
  // bus slave state
  // ************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;

  // ************************************************************
  // channel datapath
  // ************************************************************
  logic [N_CH-1:0] phys;
  logic [N_CH-1:0] logi;
  logic [N_CH-1:0] ev_on;
  logic [N_CH-1:0] ev_on_d;
  logic [16:0]     tick_cnt;
  logic [16:0]     next_tick_cnt;
  logic            ms_tick;

  // millisecond tick for delay counting
  always_comb
  begin
    ms_tick       = (tick_cnt == 17'(TICK_CYCLES - 1));
    next_tick_cnt = ms_tick ? '0 : tick_cnt + 1'b1;
  end

  // six generic channels
  generate
    for (genvar i = 0; i < N_CH; i++)
    begin : g_ch
      ium_chan #(
        .DLY_W (16)
      ) u_chan (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .pin         (din_pin[i]),
        .active_high (cfg[i][POL_BIT]),
        .use_type    (cfg[i][USE_LSB +: 2]),
        .delay_ms    (cfg[i][DLY_LSB +: 16]),
        .ms_tick     (ms_tick),
        .phys        (phys[i]),
        .logical     (logi[i]),
        .event_on    (ev_on[i])
      );
    end
  endgenerate

  logic [1:0] fix_l;

  // fixed inputs, active low to battery negative, not reassignable
  generate
    for (genvar j = 0; j < 2; j++)
    begin : g_fix
      ium_chan #(
        .DLY_W (16)
      ) u_fix (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .pin         ((j == 0) ? estop_pin : rstart_pin),
        .active_high (1'b0),
        .use_type    (2'(IUM_OFF)),
        .delay_ms    (16'h0000),
        .ms_tick     (ms_tick),
        .phys        (),
        .logical     (fix_l[j]),
        .event_on    ()
      );
    end
  endgenerate

  // routing by usage, later channel overrides earlier
  logic [NUM_QTY-1:0] next_cmd_qty;
  logic [NUM_QTY-1:0] next_event_raise;
  logic [N_CH-1:0]    next_link_state;
  logic [N_CH-1:0]    ch_on;

  always_comb
  begin
    next_cmd_qty     = '0;
    next_event_raise = '0;
    next_link_state  = '0;
    for (int i = 0; i < N_CH; i++)
    begin
      ch_on[i] = (cfg[i][USE_LSB +: 2] != 2'(IUM_OFF));
      case (cfg[i][USE_LSB +: 2])
        2'(IUM_CMD):   next_cmd_qty[cfg[i][QTY_LSB +: QTY_W]] = logi[i];
        2'(IUM_EVENT): next_event_raise[cfg[i][QTY_LSB +: QTY_W]] = ev_on[i];
        2'(IUM_LINK):  next_link_state[i] = logi[i];
        default:       ;
      endcase
    end
  end

  // ************************************************************
  // register writes and sticky events
  // ************************************************************
  always_comb
  begin
    do_write      = aw_held && w_held && !s_axi_bvalid;
    next_cfg      = cfg;
    next_mask     = mask;
    next_access   = access;
    next_stat_irq = stat_irq;
    next_bresp    = s_axi_bresp;
    if (do_write)
    begin
      next_bresp = 2'h0;
      if (aw_addr < STAT_OFS && aw_addr[1:0] == 2'h0)
      begin
        // local config accepted only at access level two or higher, with all four byte strobes
        if (access >= ACCESS_MIN && w_strb == 4'hF)
          next_cfg[aw_addr[4:2]] = w_data;
        else
          next_bresp = 2'h2;
      end
      else if (aw_addr == IRQ_OFS)
        next_stat_irq = stat_irq & ~w_data[N_CH-1:0];
      else if (aw_addr == MASK_OFS)
        next_mask = w_data[N_CH-1:0];
      else if (aw_addr == ACCESS_OFS)
        next_access = w_data[1:0];
      else if (aw_addr != STAT_OFS && aw_addr != QTY_OFS && aw_addr != ID_OFS)
        next_bresp = 2'h3;
    end
    // new event rising edge wins over clear
    next_stat_irq = next_stat_irq | (ev_on & ~ev_on_d);
  end

  // ************************************************************
  // bus handshakes and read mux
  // ************************************************************
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      next_rdata  = 32'h0000_0000;
      if (s_axi_araddr < STAT_OFS && s_axi_araddr[1:0] == 2'h0)
        next_rdata = cfg[s_axi_araddr[4:2]];
      else if (s_axi_araddr == STAT_OFS)
      begin
        next_rdata[PHYS_LSB +: N_CH] = phys & ch_on;
        next_rdata[LOGI_LSB +: N_CH] = logi & ch_on;
        next_rdata[FIX_LSB +: 2]     = fix_l;
      end
      else if (s_axi_araddr == IRQ_OFS)
        next_rdata[N_CH-1:0] = stat_irq;
      else if (s_axi_araddr == MASK_OFS)
        next_rdata[N_CH-1:0] = mask;
      else if (s_axi_araddr == ACCESS_OFS)
        next_rdata[1:0] = access;
      else if (s_axi_araddr == QTY_OFS)
        next_rdata = cmd_qty;
      else if (s_axi_araddr == ID_OFS)
        next_rdata = ID_VALUE;
      else
        next_rresp = 2'h3;
    end
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < N_CH; i++)
        cfg[i] <= CFG_RST; // off, active high
      stat_irq      <= '0;
      mask          <= '0;
      access        <= 2'h0;
      tick_cnt      <= '0;
      ev_on_d       <= '0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      cmd_qty       <= '0;
      event_raise   <= '0;
      link_state    <= '0;
      estop         <= 1'b0;
      remote_start  <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      cfg           <= next_cfg;
      stat_irq      <= next_stat_irq;
      mask          <= next_mask;
      access        <= next_access;
      tick_cnt      <= next_tick_cnt;
      ev_on_d       <= ev_on;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      cmd_qty       <= next_cmd_qty;
      event_raise   <= next_event_raise;
      link_state    <= next_link_state;
      estop         <= fix_l[0];
      remote_start  <= fix_l[1];
      irq           <= |(next_stat_irq & next_mask);
    end
  end

endmodule

// ==== logic/ium_pkg.sv ====
package ium_pkg;

  // ************************************************************
  // channel counts
  // ************************************************************
  localparam int NUM_CH    = 6;
  localparam int QTY_W     = 5;
  localparam int NUM_QTY   = 32;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] CFG0_OFS    = 8'h00; // channel n config at CFG0_OFS + 4*n
  localparam logic [7:0] STAT_OFS    = 8'h18;
  localparam logic [7:0] IRQ_OFS     = 8'h1C;
  localparam logic [7:0] MASK_OFS    = 8'h20;
  localparam logic [7:0] ACCESS_OFS  = 8'h24;
  localparam logic [7:0] QTY_OFS     = 8'h28;
  localparam logic [7:0] ID_OFS      = 8'h2C;

  // ************************************************************
  // channel config fields
  // ************************************************************
  localparam int USE_LSB   = 0;  // [1:0] usage type
  localparam int POL_BIT   = 2;  // 1 = active high
  localparam int QTY_LSB   = 8;  // [12:8] quantity / event id
  localparam int DLY_LSB   = 16; // [31:16] delay, ms

  // ************************************************************
  // status register fields
  // ************************************************************
  localparam int PHYS_LSB  = 0;  // [5:0] physical levels
  localparam int LOGI_LSB  = 8;  // [13:8] logical states
  localparam int FIX_LSB   = 16; // [17:16] estop, remote start

  // ************************************************************
  // reset and access values
  // ************************************************************
  localparam logic [31:0] CFG_RST      = 32'h0000_0004;
  localparam logic [1:0]  ACCESS_MIN   = 2'h2;
  localparam logic [31:0] ID_VALUE     = 32'h00A5_0001; // arbitrary value

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ      = 125;
  localparam int MS_NS        = 1000000;
  localparam int CLK_NS       = 8;
  localparam int TICK_CYCLES  = MS_NS / CLK_NS; // one millisecond

  typedef enum logic [1:0]
  {
    IUM_OFF,
    IUM_CMD,
    IUM_EVENT,
    IUM_LINK
  } ium_use_t;

endpackage

// ==== logic/ium_chan.sv ====
`timescale 1ns/10ps
// ************************************************************
// one input channel: synchroniser, polarity, delay qualifier
// ************************************************************
module ium_chan
  import ium_pkg::*;
#(
  parameter int DLY_W = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             pin,
  input  wire logic             active_high,
  input  wire logic [1:0]       use_type,
  input  wire logic [DLY_W-1:0] delay_ms,
  input  wire logic             ms_tick,
  output logic                  phys,
  output logic                  logical,
  output logic                  event_on
);

  logic [2:0]       sync;
  logic [2:0]       next_sync;
  logic             next_phys;
  logic [DLY_W-1:0] dcnt;
  logic [DLY_W-1:0] next_dcnt;
  logic             next_event_on;

  // three stage sync, change counts when stages two and three agree
  always_comb
  begin
    next_sync = {sync[1:0], pin};
    next_phys = (sync[1] == sync[2]) ? sync[2] : phys;
  end

  // polarity maps level to logical state
  assign logical = active_high ? phys : ~phys;

  // event qualified by delay, only for event usage
  always_comb
  begin
    next_dcnt     = dcnt;
    next_event_on = event_on;
    if ((use_type != 2'(IUM_EVENT)) || !logical)
    begin
      next_dcnt     = '0;
      next_event_on = 1'b0;
    end
    else if (dcnt >= delay_ms)
      next_event_on = 1'b1;
    else if (ms_tick)
      next_dcnt = dcnt + 1'b1;
  end

  // pull-up means idle level is high
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sync     <= 3'h7;
      phys     <= 1'b1;
      dcnt     <= '0;
      event_on <= 1'b0;
    end
    else
    begin
      sync     <= next_sync;
      phys     <= next_phys;
      dcnt     <= next_dcnt;
      event_on <= next_event_on;
    end
  end

endmodule

// ==== sim/ium_contacts.sv ====
`timescale 1ns/10ps
// ************************************************************
// switch contacts to battery negative, pulled up inside
// ************************************************************
module ium_contacts
(
  input  wire logic [5:0] shut,
  input  wire logic [1:0] fix_shut,
  output logic [5:0]      pin,
  output logic [1:0]      fix_pin
);
  // closed contact sinks to battery negative, open reads pull-up high
  assign pin     = ~shut;
  assign fix_pin = ~fix_shut;
endmodule

// ==== sim/ium_top_checker.sv ====
`timescale 1ns/10ps
// ************************************************************
// port checks of the input mapper
// ************************************************************
module ium_top_checker
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        estop_pin,
  input wire logic        rstart_pin,
  input wire logic        estop,
  input wire logic        remote_start,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // quiet pin then a change, and a write taken
  sequence stop_quiet_fall;
    estop_pin [*6] ##1 !estop_pin;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  estop_on_a: assert property (!estop_pin [*7] |-> estop)
    else $error("estop missing while stop pin low");
  estop_off_a: assert property (estop_pin [*7] |-> !estop)
    else $error("estop raised while stop pin high");
  rstart_on_a: assert property (!rstart_pin [*7] |-> remote_start)
    else $error("remote start missing while pin low");
  sync_delay_a: assert property (stop_quiet_fall |=> !estop [*2])
    else $error("estop bypassed the synchroniser");
  write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
// ************************************************************
// bench for the input mapper
// ************************************************************
module tb
  import ium_pkg::*;
;
  logic        sys_clk;
  logic        rst_b;
  logic [5:0]  shut;
  logic [1:0]  fix_shut;
  logic [5:0]  din_pin;
  logic [1:0]  fix_pin;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] cmd_qty;
  logic [31:0] event_raise;
  logic [5:0]  link_state;
  logic        estop;
  logic        remote_start;
  logic        irq;
  int          miscompares;
  int          samples_checked;

  // ************************************************************
  // design and contacts
  // ************************************************************
  ium_top i_dut (.sys_clk, .rst_b, .din_pin, .estop_pin(fix_pin[0]), .rstart_pin(fix_pin[1]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_qty,
    .event_raise, .link_state, .estop, .remote_start, .irq);
  ium_contacts i_sw (.shut, .fix_shut, .pin(din_pin), .fix_pin);

  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 60)
    begin
      miscompares++;
      $display("[FAIL] bus wait expected answer seen timeout");
      results();
    end
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // write one word, check the response code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
    s_axi_bready <= 1'b0;
    guard(n);
    chk($sformatf("bresp %h", a), 32'(s_axi_bresp), 32'(er));
  endtask

  // read one word, check data and response code
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
    s_axi_rready <= 1'b0;
    guard(n);
    chk($sformatf("rdata %h", a), s_axi_rdata, ed);
    chk($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(er));
  endtask

  // let pins cross the synchroniser, then check routed outputs
  task automatic outs(input logic [31:0] eq, input logic [31:0] ee, input logic [5:0] el);
    settle(8);
    chk("cmd_qty", cmd_qty, eq);
    chk("event_raise", event_raise, ee);
    chk("link_state", 32'(link_state), 32'(el));
  endtask

  function automatic logic [31:0] cf(input logic [1:0] u, input logic p, input logic [4:0] q,
                                     input logic [15:0] d);
    return {d, 3'h0, q, 5'h00, p, u};
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    for (int k = 0; k < NUM_CH; k++)
      rd(CFG0_OFS + 8'(4 * k), CFG_RST, 2'h0);
    rd(ID_OFS, ID_VALUE, 2'h0);
    rd(8'h40, 32'h0, 2'h3);
    outs(32'h0, 32'h0, 6'h00);
  endtask

  task automatic t_access;
    wr(CFG0_OFS, cf(2'h1, 1'b1, 5'h03, 16'h0000), 2'h2);
    wr(ACCESS_OFS, 32'h1, 2'h0);
    wr(CFG0_OFS, cf(2'h1, 1'b1, 5'h03, 16'h0000), 2'h2);
    rd(CFG0_OFS, CFG_RST, 2'h0);
    wr(ACCESS_OFS, 32'h2, 2'h0);
    wr(CFG0_OFS, cf(2'h1, 1'b1, 5'h03, 16'h0000), 2'h0);
    rd(CFG0_OFS, cf(2'h1, 1'b1, 5'h03, 16'h0000), 2'h0);
    s_axi_wstrb <= 4'h3;
    wr(CFG0_OFS, cf(2'h2, 1'b1, 5'h03, 16'h0000), 2'h2);
    s_axi_wstrb <= 4'hF;
    wr(8'h40, 32'h0, 2'h3);
  endtask

  task automatic t_cmd;
    outs(32'h8, 32'h0, 6'h00);
    rd(STAT_OFS, 32'h0101, 2'h0);
    shut <= 6'h01;
    outs(32'h0, 32'h0, 6'h00);
    rd(STAT_OFS, 32'h0000, 2'h0);
    wr(CFG0_OFS, cf(2'h1, 1'b0, 5'h03, 16'h0000), 2'h0);
    outs(32'h8, 32'h0, 6'h00);
    rd(STAT_OFS, 32'h0100, 2'h0);
    shut <= 6'h00;
  endtask

  task automatic t_prio;
    wr(CFG0_OFS + 8'h04, cf(2'h1, 1'b1, 5'h05, 16'h0000), 2'h0);
    wr(CFG0_OFS + 8'h10, cf(2'h1, 1'b1, 5'h05, 16'h0000), 2'h0);
    shut <= 6'h10;
    outs(32'h0, 32'h0, 6'h00);
    shut <= 6'h02;
    outs(32'h20, 32'h0, 6'h00);
    shut <= 6'h10;
    wr(CFG0_OFS + 8'h10, cf(2'h0, 1'b1, 5'h05, 16'h0000), 2'h0);
    outs(32'h20, 32'h0, 6'h00);
  endtask

  task automatic t_link;
    wr(CFG0_OFS + 8'h08, cf(2'h3, 1'b1, 5'h07, 16'h0000), 2'h0);
    outs(32'h20, 32'h0, 6'h04);
    rd(IRQ_OFS, 32'h0, 2'h0);
    rd(QTY_OFS, 32'h20, 2'h0);
  endtask

  task automatic t_event;
    wr(CFG0_OFS + 8'h0C, cf(2'h2, 1'b1, 5'h09, 16'h0002), 2'h0);
    settle(1000);
    outs(32'h20, 32'h0, 6'h04);
    wr(CFG0_OFS + 8'h0C, cf(2'h2, 1'b1, 5'h09, 16'h0000), 2'h0);
    outs(32'h20, 32'h200, 6'h04);
    rd(IRQ_OFS, 32'h8, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    wr(MASK_OFS, 32'h8, 2'h0);
    settle(2);
    chk("irq", 32'(irq), 32'h1);
    wr(IRQ_OFS, 32'h8, 2'h0);
    settle(2);
    chk("irq", 32'(irq), 32'h0);
    shut <= 6'h18;
    outs(32'h20, 32'h0, 6'h04);
  endtask

  task automatic t_fixed;
    fix_shut <= 2'h3;
    outs(32'h20, 32'h0, 6'h04);
    chk("estop", 32'(estop), 32'h1);
    chk("remote_start", 32'(remote_start), 32'h1);
    rd(STAT_OFS, 32'h0003_0607, 2'h0);
    fix_shut <= 2'h0;
    settle(8);
    chk("estop", 32'(estop), 32'h0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    shut = 6'h00;
    fix_shut = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    settle(3);
    t_reset();
    t_access();
    t_cmd();
    t_prio();
    t_link();
    t_event();
    t_fixed();
    results();
  end
endmodule

bind ium_top ium_top_checker i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .estop_pin(estop_pin),
  .rstart_pin(rstart_pin), .estop(estop), .remote_start(remote_start),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
